/* cbw_top.sv */
// The APB interface to the registers is this design's own decision.
`include "cbw_regs.svh"
`default_nettype none

module cbw_top #(
  parameter int FUNC_INDEX = 0,
  parameter int NUM_WIN    = 2
) (
  // Clock and synchronous reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // Register bus, slave side
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Address offers from both sides of the bridge
  input  wire logic        HOST_IO_VALID_I,
  input  wire logic [31:0] HOST_IO_ADDR_I,
  input  wire logic        CARD_IO_VALID_I,
  input  wire logic [31:0] CARD_IO_ADDR_I,
  // Forwarding verdicts and exported interrupt controls
  output logic             HOST_TO_CARD_O,
  output logic             CARD_TO_HOST_O,
  output logic             INTERRUPT_TIE_BIT_O,
  output logic [1:0]       IRQ_MODE_O
);

  // Only two functions and two windows exist in the bridge
  // The decode below names both windows, so other counts are refused outright
  if (FUNC_INDEX < 0 || FUNC_INDEX > 1) begin : g_bad_func
    $error("FUNC_INDEX must be 0 or 1");
  end
  if (NUM_WIN != 2) begin : g_bad_win
    $error("NUM_WIN must be 2");
  end
  // Bound field in the header must fill one half of the window type
  if (`CBW_BOUND_MSB - `CBW_BOUND_LSB + 1 != $bits(cbw_pkg::cbw_window_t) / 2) begin : g_bad_field
    $error("bound field width does not match window type");
  end

  // Register state
  cbw_pkg::cbw_window_t   win_reg [NUM_WIN];
  cbw_pkg::cbw_irq_ctrl_t ctrl_reg;
  logic [7:0]             line_reg;
  logic [7:0]             pin_code;

  // Bus decode
  logic [31:0]            rdata_next;
  logic                   err_next;
  logic                   access;
  logic                   answer_due;
  logic                   wr_commit;
  logic [9:0]             idx;
  logic                   sel_win0_lo;
  logic                   sel_win0_hi;
  logic                   sel_win1_lo;
  logic                   sel_win1_hi;
  logic                   sel_line;
  logic                   sel_ctrl;

  // Forwarding decode
  logic [NUM_WIN-1:0]     host_in_win;
  logic [NUM_WIN-1:0]     card_in_win;
  logic                   host_hit;
  logic                   card_hit;

  // Window active when either bound is nonzero
  function automatic logic win_active(input cbw_pkg::cbw_window_t w);
    return (w.lower != `CBW_WIN_RESET) || (w.upper != `CBW_WIN_RESET);
  endfunction

  // Address inside window; limit low bits taken as ones, page fixed at 0
  // The limit reads back with zero low bits, but the compare must reach the
  // last byte of the top doubleword, or that doubleword would be lost
  function automatic logic win_hit(input cbw_pkg::cbw_window_t w,
                                   input logic [31:0] a);
    logic [31:0] lo;
    logic [31:0] hi;
    lo = {16'h0000, w.lower, 2'b00};
    hi = {16'h0000, w.upper, 2'b11};
    return win_active(w) && (a >= lo) && (a <= hi);
  endfunction

  // Read view of a bound: only bits 15..2 can be nonzero
  function automatic logic [31:0] bound_view(input logic [13:0] b);
    return {16'h0000, b, 2'b00};
  endfunction

  // Register select from the word index; the header keeps indices 8 bits wide
  // so the widening happens here once instead of at every compare
  function automatic logic is_reg(input logic [9:0] i,
                                  input logic [7:0] code);
    return i == {2'b00, code};
  endfunction

  // Pin code: tie forces the first pin for both functions
  // Signaling mode is deliberately not an input, it never changes the code
  function automatic logic [7:0] pin_value(input logic tie,
                                           input int   func);
    logic [7:0] code;
    code = `CBW_PIN_INTB;
    if (tie || func == 0) begin
      code = `CBW_PIN_INTA;
    end
    return code;
  endfunction

  // Word index of the access; byte address bits 1..0 are ignored
  assign idx       = PADDR_I[11:2];
  assign access    = PSEL_I && PENABLE_I;
  // Write lands only on the edge where the master sees pready high
  assign wr_commit = access && PREADY_O && PWRITE_I && !err_next;
  // Answer owed on the first access-phase edge only
  assign answer_due = access && !PREADY_O;

  // One decode per writable register, shared by the write processes
  assign sel_win0_lo = is_reg(idx, `CBW_IDX_WIN0_LO);
  assign sel_win0_hi = is_reg(idx, `CBW_IDX_WIN0_HI);
  assign sel_win1_lo = is_reg(idx, `CBW_IDX_WIN1_LO);
  assign sel_win1_hi = is_reg(idx, `CBW_IDX_WIN1_HI);
  assign sel_line    = is_reg(idx, `CBW_IDX_IRQ_LINE);
  assign sel_ctrl    = is_reg(idx, `CBW_IDX_IRQ_CTRL);

  // Pin report follows the live tie bit, not the exported copy
  assign pin_code    = pin_value(ctrl_reg.tie, FUNC_INDEX);

  // Read mux and unmapped decode
  always_comb begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    unique case (idx)
      10'(`CBW_IDX_WIN0_LO):  rdata_next = bound_view(win_reg[0].lower);
      10'(`CBW_IDX_WIN0_HI):  rdata_next = bound_view(win_reg[0].upper);
      10'(`CBW_IDX_WIN1_LO):  rdata_next = bound_view(win_reg[1].lower);
      10'(`CBW_IDX_WIN1_HI):  rdata_next = bound_view(win_reg[1].upper);
      10'(`CBW_IDX_IRQ_LINE): rdata_next = {24'h00_0000, line_reg};
      // Pin report ignores mode, only tie and function matter
      10'(`CBW_IDX_IRQ_PIN):  rdata_next = {24'h00_0000, pin_code};
      10'(`CBW_IDX_IRQ_CTRL): rdata_next = {29'h0000_0000, ctrl_reg.mode, ctrl_reg.tie};
      default:               err_next = 1'b1;
    endcase
  end

  // Ready: one wait state, then a single-cycle pulse; the second edge ends the access
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PREADY_O <= 1'b0;
    end else begin
      PREADY_O <= answer_due;
    end
  end

  // Read data only in the ready cycle of a read, zero otherwise so stale data never leaks
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else begin
      PRDATA_O <= (answer_due && !PWRITE_I) ? rdata_next : 32'h0000_0000;
    end
  end

  // Error flag rides with ready for unmapped words
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      PSLVERR_O <= 1'b0;
    end else begin
      PSLVERR_O <= answer_due && err_next;
    end
  end

  // Window bounds; only bits 15..2 of the write data are stored
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      for (int i = 0; i < NUM_WIN; i++) begin
        win_reg[i] <= '{lower: `CBW_WIN_RESET, upper: `CBW_WIN_RESET};
      end
    end else if (wr_commit) begin
      // The fixed bits are never stored, so a write cannot disturb them
      // Window 0
      if (sel_win0_lo) begin
        win_reg[0].lower <= PWDATA_I[`CBW_BOUND_MSB:`CBW_BOUND_LSB];
      end
      if (sel_win0_hi) begin
        win_reg[0].upper <= PWDATA_I[`CBW_BOUND_MSB:`CBW_BOUND_LSB];
      end
      // Window 1
      if (sel_win1_lo) begin
        win_reg[1].lower <= PWDATA_I[`CBW_BOUND_MSB:`CBW_BOUND_LSB];
      end
      if (sel_win1_hi) begin
        win_reg[1].upper <= PWDATA_I[`CBW_BOUND_MSB:`CBW_BOUND_LSB];
      end
    end
  end

  // Routing scratch byte, never consulted by the decode logic
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      line_reg <= `CBW_LINE_RESET;
    end else if (wr_commit && sel_line) begin
      line_reg <= PWDATA_I[7:0];
    end
  end

  // Interrupt tie and signaling mode
  // Mode is stored, read back and exported on IRQ_MODE_O only; the signaling itself lives elsewhere
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      ctrl_reg.tie  <= 1'b0;
      ctrl_reg.mode <= cbw_pkg::CBW_SER_ALL;
    end else if (wr_commit && sel_ctrl) begin
      ctrl_reg.tie  <= PWDATA_I[`CBW_TIE_BIT];
      ctrl_reg.mode <= cbw_pkg::cbw_mode_t'(PWDATA_I[`CBW_MODE_MSB:`CBW_MODE_LSB]);
    end
  end

  // Hit test per window; vectors keep the per-window view for debug
  always_comb begin
    host_in_win = '0;
    card_in_win = '0;
    for (int i = 0; i < NUM_WIN; i++) begin
      host_in_win[i] = win_hit(win_reg[i], HOST_IO_ADDR_I);
      card_in_win[i] = win_hit(win_reg[i], CARD_IO_ADDR_I);
    end
  end

  // Either window claims the address
  assign host_hit = |host_in_win;
  assign card_hit = |card_in_win;

  // Host verdict, one cycle after the address is offered
  // Registered so the verdict never glitches while the address settles
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      HOST_TO_CARD_O <= 1'b0;
    end else begin
      HOST_TO_CARD_O <= HOST_IO_VALID_I && host_hit;
    end
  end

  // Card verdict: cycles outside every window belong upstream
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      CARD_TO_HOST_O <= 1'b0;
    end else begin
      CARD_TO_HOST_O <= CARD_IO_VALID_I && !card_hit;
    end
  end

  // Tie bit exported to the interrupt logic, one cycle behind the register
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      INTERRUPT_TIE_BIT_O <= 1'b0;
    end else begin
      INTERRUPT_TIE_BIT_O <= ctrl_reg.tie;
    end
  end

  // Mode exported; serial-for-both shows even while reset is held
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      IRQ_MODE_O <= cbw_pkg::CBW_SER_ALL;
    end else begin
      IRQ_MODE_O <= ctrl_reg.mode;
    end
  end

endmodule // cbw_top
`default_nettype wire

/* cbw_regs.svh */
`ifndef CBW_REGS_SVH
`define CBW_REGS_SVH
// Register indices; byte address is four times the index
`define CBW_IDX_WIN0_LO   8'h2c
`define CBW_IDX_WIN0_HI   8'h30
`define CBW_IDX_WIN1_LO   8'h34
`define CBW_IDX_WIN1_HI   8'h38
`define CBW_IDX_IRQ_LINE  8'h3c
`define CBW_IDX_IRQ_PIN   8'h3d
`define CBW_IDX_IRQ_CTRL  8'h40
// Writable bound field inside a window register
`define CBW_BOUND_MSB     15
`define CBW_BOUND_LSB     2
// Control register fields
`define CBW_TIE_BIT       0
`define CBW_MODE_LSB      1
`define CBW_MODE_MSB      2
// Reset values and pin codes
`define CBW_WIN_RESET     14'h0000
`define CBW_LINE_RESET    8'hff
`define CBW_PIN_INTA      8'h01
`define CBW_PIN_INTB      8'h02
`endif

/* cbw_pkg.sv */
`default_nettype none
package cbw_pkg;
  // Interrupt signaling modes, serial-for-both is the reset choice
  typedef enum logic [1:0] {
    CBW_PAR_PCI,
    CBW_PAR_IRQ_PAR_PCI,
    CBW_SER_IRQ_PAR_PCI,
    CBW_SER_ALL
  } cbw_mode_t;

  // Writable part of one I/O window, bits 15..2 of each bound
  typedef struct packed {
    logic [13:0] lower;
    logic [13:0] upper;
  } cbw_window_t;

  // Interrupt routing controls
  typedef struct packed {
    logic      tie;
    cbw_mode_t mode;
  } cbw_irq_ctrl_t;
endpackage
`default_nettype wire

/* cbw_top_props.sv */
`default_nettype none
module cbw_top_props #(
  parameter int FUNC_INDEX = 0
) (
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic        PSEL_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  input wire logic        HOST_IO_VALID_I,
  input wire logic [31:0] HOST_IO_ADDR_I,
  input wire logic        CARD_IO_VALID_I,
  input wire logic [31:0] CARD_IO_ADDR_I,
  input wire logic        HOST_TO_CARD_O,
  input wire logic        CARD_TO_HOST_O,
  input wire logic        INTERRUPT_TIE_BIT_O,
  input wire logic [1:0]  IRQ_MODE_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  logic rd_ok;
  // Read answer cycle, address still held by the master
  assign rd_ok = PREADY_O && PSEL_I && !PWRITE_I;
  a_pin_by_tie: assert property (rd_ok && PADDR_I == 12'h0f4 |->
    PRDATA_O == ((INTERRUPT_TIE_BIT_O || FUNC_INDEX == 0) ? 32'h1 : 32'h2)) else $error("pin report wrong");
  a_line_narrow: assert property (rd_ok && PADDR_I == 12'h0f0 |-> PRDATA_O[31:8] == 24'h0)
    else $error("line register upper bits set");
  a_lower_ro_bits: assert property (rd_ok && (PADDR_I == 12'h0b0 || PADDR_I == 12'h0d0) |->
    PRDATA_O[31:16] == 16'h0 && PRDATA_O[1:0] == 2'h0) else $error("lower bound fixed bits set");
  a_upper_ro_bits: assert property (rd_ok && (PADDR_I == 12'h0c0 || PADDR_I == 12'h0e0) |->
    PRDATA_O[31:16] == 16'h0 && PRDATA_O[1:0] == 2'h0) else $error("upper bound fixed bits set");
  a_host_idle: assert property (!HOST_IO_VALID_I |=> !HOST_TO_CARD_O) else $error("host forward when idle");
  a_host_page: assert property (HOST_IO_VALID_I && HOST_IO_ADDR_I[31:16] != 16'h0 |=> !HOST_TO_CARD_O)
    else $error("host forward outside page");
  a_card_idle: assert property (!CARD_IO_VALID_I |=> !CARD_TO_HOST_O) else $error("card forward when idle");
  a_card_page: assert property (CARD_IO_VALID_I && CARD_IO_ADDR_I[31:16] != 16'h0 |=> CARD_TO_HOST_O)
    else $error("card address outside page kept");
  a_mode_reset: assert property ($fell(RST_I) |=> IRQ_MODE_O == 2'h3) else $error("mode not serial");
  c_host_hit: cover property (HOST_TO_CARD_O);
  c_card_fwd: cover property (CARD_TO_HOST_O);
  c_unmapped: cover property (PSLVERR_O);
endmodule : cbw_top_props
`default_nettype wire

/* cbw_io_agent.sv */
`default_nettype none
module cbw_io_agent (
  input  wire logic        clk_i,
  output logic             host_valid_o,
  output logic      [31:0] host_addr_o,
  output logic             card_valid_o,
  output logic      [31:0] card_addr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle offers at time zero
  initial begin
    {host_valid_o, card_valid_o, host_addr_o, card_addr_o} = '0;
  end
  // One-cycle offer; released lines show the inverse so a stale address never looks fresh
  task automatic offer(input logic card, input logic [31:0] a);
    @(posedge clk_i);
    host_valid_o <= !card;
    card_valid_o <= card;
    host_addr_o  <= card ? ~host_addr_o : a;
    card_addr_o  <= card ? a : ~card_addr_o;
    @(posedge clk_i);
    {host_valid_o, card_valid_o} <= 2'b00;
    host_addr_o  <= ~a;
    card_addr_o  <= ~a;
  endtask
endmodule : cbw_io_agent
`default_nettype wire

/* tb_top.sv */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er, hv, cv, h2c, c2h, tie;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, ha, ca;
  logic [1:0]  mode;
  int          num_errors = 0, n_tests = 0, cyc = 0;
  always #25 clk = ~clk;
  cbw_top #(.FUNC_INDEX(1)) dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .HOST_IO_VALID_I(hv), .HOST_IO_ADDR_I(ha), .CARD_IO_VALID_I(cv), .CARD_IO_ADDR_I(ca),
    .HOST_TO_CARD_O(h2c), .CARD_TO_HOST_O(c2h), .INTERRUPT_TIE_BIT_O(tie), .IRQ_MODE_O(mode));
  cbw_io_agent far (.clk_i(clk), .host_valid_o(hv), .host_addr_o(ha), .card_valid_o(cv), .card_addr_o(ca));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Setup, access, then hold until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic fwd(input logic card, input logic [31:0] a, input logic exp);
    far.offer(card, a);
    @(posedge clk);
    chk(card ? "card_fwd" : "host_fwd", {31'h0, card ? c2h : h2c}, {31'h0, exp});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 6; i++) rdc("reset", 12'h0b0 + 12'(i * 16) - 12'(i / 5 * 12), i == 4 ? 32'hff : i == 5 ? 32'h2 : 32'h0);
    rdc("mode", 12'h100, 32'h6);
    chk("mode_out", {30'h0, mode}, 32'h3);
    fwd(1'b0, 32'h0, 1'b0);
    fwd(1'b1, 32'h0, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_window;
    for (int i = 0; i < 4; i++) apb(1'b1, 12'h0b0 + 12'(i * 16), 32'hffffffff);
    for (int i = 0; i < 4; i++) rdc("bound", 12'h0b0 + 12'(i * 16), 32'h0000fffc);
    apb(1'b1, 12'h0d0, 32'h0);
    apb(1'b1, 12'h0e0, 32'h4);
    fwd(1'b0, 32'h0, 1'b1);
    fwd(1'b0, 32'h8, 1'b0);
    apb(1'b1, 12'h0e0, 32'h0);
    apb(1'b1, 12'h0b0, 32'h1000);
    apb(1'b1, 12'h0c0, 32'h1ff0);
    fwd(1'b0, 32'h0, 1'b0);
    fwd(1'b0, 32'h0ffc, 1'b0);
    fwd(1'b0, 32'h1000, 1'b1);
    fwd(1'b0, 32'h1ff3, 1'b1);
    fwd(1'b0, 32'h1ff4, 1'b0);
    fwd(1'b0, 32'h11000, 1'b0);
    fwd(1'b1, 32'h1800, 1'b0);
    fwd(1'b1, 32'h10000, 1'b1);
    $display("window test done");
  endtask
  task automatic t_irq;
    apb(1'b1, 12'h0f0, 32'hffffff5a);
    rdc("line", 12'h0f0, 32'h5a);
    rdc("unmapped", 12'h000, 32'h0);
    chk("slverr", {31'h0, er}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'h100, 32'(i));
      rdc("pin", 12'h0f4, i % 2 ? 32'h1 : 32'h2);
      chk("tie_out", {31'h0, tie}, 32'(i % 2));
    end
    $display("irq test done");
  endtask
  // Cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_window;
    t_irq;
    tally_and_finish;
  end
endmodule : tb_top
bind cbw_top cbw_top_props #(.FUNC_INDEX(FUNC_INDEX)) props (.CLK_I(CLK_I), .RST_I(RST_I), .PSEL_I(PSEL_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .HOST_IO_VALID_I(HOST_IO_VALID_I), .HOST_IO_ADDR_I(HOST_IO_ADDR_I), .CARD_IO_VALID_I(CARD_IO_VALID_I),
  .CARD_IO_ADDR_I(CARD_IO_ADDR_I), .HOST_TO_CARD_O(HOST_TO_CARD_O), .CARD_TO_HOST_O(CARD_TO_HOST_O),
  .INTERRUPT_TIE_BIT_O(INTERRUPT_TIE_BIT_O), .IRQ_MODE_O(IRQ_MODE_O));
`default_nettype wire
